/* hw/assc_pkg.sv */
// package: constants, register map, field layouts and types of the serial channel
package assc_pkg;
    // ****************************************************************
    // clock and bit rates
    // ****************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int OVS = 16;
    localparam int ASYNC_MAX_BAUD = 500_000;
    localparam int SYNC_MAX_BAUD = 2_000_000;
    localparam int BAUD_W = 16;
    // reload for the fastest async rate, rounded down to whole cycles
    localparam logic [BAUD_W-1:0] BAUD_RST = BAUD_W'(CLK_HZ / (ASYNC_MAX_BAUD * OVS) - 1);
    // one tick is half a shift clock period in sync mode
    localparam logic [BAUD_W-1:0] SYNC_MIN_RELOAD = BAUD_W'(CLK_HZ / (SYNC_MAX_BAUD * 2) - 1);

    // ****************************************************************
    // register map (byte addresses) and bit positions
    // ****************************************************************
    localparam int ADR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_TXD = 8'h08;
    localparam logic [7:0] OFS_RXD = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_ICLR = 8'h14;
    localparam logic [7:0] OFS_IEN = 8'h18;
    localparam int IRQ_N = 4;
    localparam int IRQ_TBUF = 0;
    localparam int IRQ_TXC = 1;
    localparam int IRQ_RX = 2;
    localparam int IRQ_ERR = 3;
    localparam int ST_TXBUSY = 8;
    localparam int ST_RXFULL = 9;
    localparam int ST_PERR = 10;
    localparam int ST_FERR = 11;
    localparam int ST_OERR = 12;
    localparam int CTRL_W = 10;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam int DATA_W = 9;
    localparam int SYNC_BITS = 8;
    localparam int FRAME_MAX = 13;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_A8 = 2'h0, MODE_A9 = 2'h1, MODE_AWAKE = 2'h2, MODE_SYNC = 2'h3
    } assc_mode_t;
    typedef struct packed {
        logic rx_en;
        logic wake_filter;
        logic loopback;
        logic ovr_en;
        logic frm_en;
        logic par_odd;
        logic par_en;
        logic two_stop;
        assc_mode_t mode;
    } assc_cfg_t;
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic par_err;
        logic frm_err;
    } assc_rx_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'h1, TX_ASYNC = 3'h2, TX_SYNC = 3'h4
    } assc_tx_st_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'h1, RX_START = 3'h2, RX_DATA = 3'h4
    } assc_rx_st_t;
endpackage

/* hw/assc_baud_gen.sv */
// reloadable down-counter that makes the channel's baud tick
`timescale 1ns/100ps
module assc_baud_gen #(
    parameter int W = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic run,
    input wire logic [W-1:0] reload,
    output logic tick
);
    logic [W-1:0] cnt_q;

    if (W < 4 || W > 24) begin : g_chk
        $error("assc_baud_gen: unsupported counter width");
    end

    // tick period is reload+1 cycles; a new reload takes effect at the next wrap
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (!run) begin
                cnt_q <= reload;
            end else if (cnt_q == '0) begin
                cnt_q <= reload; // (R14)
                tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // assc_baud_gen

/* hw/assc_rx.sv */
// oversampling asynchronous receiver of the serial channel
`timescale 1ns/100ps
module assc_rx (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic tick,
    input wire logic en,
    input wire logic rxd,
    input wire logic nine,
    input wire logic par_en,
    input wire logic par_odd,
    output logic done,
    output assc_pkg::assc_rx_t res
);
    assc_pkg::assc_rx_st_t st_q;
    logic [3:0] sub_q;
    logic [3:0] nbit_q;
    logic [9:0] sh_q;
    logic [3:0] nwant;
    logic [9:0] al;
    logic [8:0] dat;

    assign nwant = (nine ? 4'h9 : 4'h8) + {3'h0, par_en};
    assign al = sh_q >> (4'hA - nbit_q);
    assign dat = nine ? al[8:0] : {1'b0, al[7:0]};

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= assc_pkg::RX_IDLE;
            sub_q <= 4'h0;
            nbit_q <= 4'h0;
            sh_q <= 10'h000;
            done <= 1'b0;
            res <= '0;
        end else if (ce) begin
            done <= 1'b0;
            if (!en) begin
                st_q <= assc_pkg::RX_IDLE;
            end else if (tick) begin
                unique case (st_q)
                    assc_pkg::RX_IDLE: begin
                        sub_q <= 4'h0;
                        if (!rxd) st_q <= assc_pkg::RX_START;
                    end
                    assc_pkg::RX_START: begin
                        sub_q <= sub_q + 4'h1;
                        // mid start bit: a short glitch returns to idle
                        if (sub_q == 4'h7) begin
                            sub_q <= 4'h0;
                            nbit_q <= 4'h0;
                            st_q <= rxd ? assc_pkg::RX_IDLE : assc_pkg::RX_DATA;
                        end
                    end
                    assc_pkg::RX_DATA: begin
                        sub_q <= sub_q + 4'h1;
                        if (sub_q == 4'hF && nbit_q != nwant) begin
                            sh_q <= {rxd, sh_q[9:1]}; // (R8)
                            nbit_q <= nbit_q + 4'h1;
                        end else if (sub_q == 4'hF) begin
                            done <= 1'b1;
                            res.data <= dat;
                            res.par_err <= par_en & (^dat ^ al[nine ? 9 : 8] ^ par_odd); // (R10)
                            res.frm_err <= ~rxd; // (R11)
                            st_q <= assc_pkg::RX_IDLE;
                        end
                    end
                    default: st_q <= assc_pkg::RX_IDLE;
                endcase
            end
        end
    end
endmodule // assc_rx

/* hw/assc_top.sv */
// serial channel: wishbone registers, transmitter, sync engine, interrupts
// ****************************************************************
// Summary of operation
// (R1) async mode sends and receives at once, up to 500 KBaud from 100 MHz.
// (R2) sync mode is half duplex, one direction at a time, up to 2.0 MBaud.
// (R3) a programmable baud generator reaches standard rates from the core clock.
// (R4) transmit buffer, transmit done, receive and error have separate requests.
// (R5) an async frame is a start bit, 8 or 9 data bits and one or two stop bits.
// (R6) a wake mode sends 8 data bits plus a bit that marks an address character.
// (R7) sync mode shifts whole bytes on a shift clock that this channel makes.
// (R8) characters go least significant bit first in every mode and direction.
// (R9) loop back feeds the transmitted data to the receiver internally.
// (R10) with parity on, a parity bit is sent and a wrong received one is flagged.
// (R11) with framing check on, a missing stop bit is flagged as framing error.
// (R12) a character completing while the previous one is unread is an overrun.
// (R13) reset returns every setting and flag to inactive, with the line idle high; the baud reload resets to BAUD_RST (11), not 0.
// (R14) the baud generator is a down-counter reloaded from a programmable value.
// ****************************************************************
`timescale 1ns/100ps
module assc_top (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [assc_pkg::ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack,
    output logic txd,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic irq,
    output logic [assc_pkg::IRQ_N-1:0] irq_vec
);
    // ****************************************************************
    // state
    // ****************************************************************
    assc_pkg::assc_cfg_t cfg_q;
    logic [assc_pkg::BAUD_W-1:0] baud_q;
    logic [assc_pkg::IRQ_N-1:0] stat_q;
    logic [assc_pkg::IRQ_N-1:0] ien_q;
    logic perr_q, ferr_q, oerr_q;
    logic rx_full_q;
    logic [assc_pkg::DATA_W-1:0] rbuf_q;
    assc_pkg::assc_tx_st_t tx_st_q;
    logic [assc_pkg::FRAME_MAX-1:0] tx_sh_q;
    logic [3:0] tx_left_q;
    logic [3:0] tx_sub_q;
    logic syn_rx_q;
    logic samp_q;
    logic tick;
    logic wr, rd, wr_ctrl;
    logic [31:0] wmask;
    logic nine, sync_mode, sync_in;
    logic [3:0] nd;
    logic [8:0] dmask;
    logic [assc_pkg::FRAME_MAX-1:0] tx_frame;
    logic [3:0] tx_len;
    logic tx_go, tbuf_ev, txc_ev;
    logic syn_done;
    logic rxu_done;
    assc_pkg::assc_rx_t rxu_res;
    logic put;
    logic [8:0] put_data;
    logic put_perr, put_ferr;
    logic [assc_pkg::IRQ_N-1:0] ev, clr;
    logic [assc_pkg::CTRL_W-1:0] ctrl_new;
    logic [31:0] rdata;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    // ack one cycle after the strobe, dropped the cycle after
    assign wr = wb_cyc & wb_stb & wb_we & ~wb_ack;
    assign rd = wb_cyc & wb_stb & ~wb_we & ~wb_ack;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{wb_sel[b]}};
        end
    end
    assign wr_ctrl = wr && wb_adr == assc_pkg::OFS_CTRL;
    assign ctrl_new = assc_pkg::CTRL_W'((cfg_q & ~wmask) | (wb_dat_in & wmask));

    assign nine = cfg_q.mode == assc_pkg::MODE_A9 || cfg_q.mode == assc_pkg::MODE_AWAKE;
    assign sync_mode = cfg_q.mode == assc_pkg::MODE_SYNC;
    assign nd = nine ? 4'h9 : 4'h8;
    assign dmask = nine ? 9'h1FF : 9'h0FF;

    // ****************************************************************
    // baud generator and async receiver
    // ****************************************************************
    assc_baud_gen #(.W(assc_pkg::BAUD_W)) u_baud (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .ce(ce),
        .run(1'b1),
        .reload(baud_q), // (R3)
        .tick(tick)
    );

    assc_rx u_rx (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .ce(ce),
        .tick(tick),
        .en(cfg_q.rx_en & ~sync_mode), // (R1)
        .rxd(cfg_q.loopback ? txd : rxd_in), // (R9)
        .nine(nine),
        .par_en(cfg_q.par_en),
        .par_odd(cfg_q.par_odd),
        .done(rxu_done),
        .res(rxu_res)
    );

    // ****************************************************************
    // transmit frame builder
    // ****************************************************************
    always_comb begin
        tx_frame = '1;
        tx_frame[0] = 1'b0; // (R5)
        for (int i = 0; i < assc_pkg::DATA_W; i++) begin
            if (i < int'(nd)) tx_frame[1+i] = wb_dat_in[i]; // (R8)
        end
        if (cfg_q.par_en) begin
            tx_frame[4'h1 + nd] = ^(wb_dat_in[8:0] & dmask) ^ cfg_q.par_odd; // (R10)
        end
        tx_len = 4'h2 + nd + {3'h0, cfg_q.par_en} + {3'h0, cfg_q.two_stop}; // (R5)
    end

    assign tx_go = wr && wb_adr == assc_pkg::OFS_TXD && tx_st_q == assc_pkg::TX_IDLE;
    assign sync_in = cfg_q.loopback ? tx_sh_q[0] : rxd_in; // (R9)
    assign syn_done = tick && tx_st_q == assc_pkg::TX_SYNC && txd && tx_left_q == 4'h8;
    assign tbuf_ev = tx_go;
    assign txc_ev = (tick && tx_st_q == assc_pkg::TX_ASYNC && tx_sub_q == 4'hF
                     && tx_left_q == 4'h1) || (syn_done && !syn_rx_q);

    // ****************************************************************
    // transmitter and sync shift engine
    // ****************************************************************
    // in sync mode txd is the shift clock and rxd carries the data, so
    // the sync engine and the async transmitter share one shift register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q <= assc_pkg::TX_IDLE; // (R13)
            txd <= 1'b1;
            tx_sh_q <= '1;
            tx_left_q <= 4'h0;
            tx_sub_q <= 4'h0;
            syn_rx_q <= 1'b0;
            samp_q <= 1'b0;
            rxd_oe <= 1'b0;
        end else if (ce) begin
            unique case (tx_st_q)
                assc_pkg::TX_IDLE: begin
                    txd <= 1'b1;
                    tx_sub_q <= 4'h0;
                    if (tx_go && !sync_mode) begin
                        tx_sh_q <= tx_frame;
                        tx_left_q <= tx_len;
                        tx_st_q <= assc_pkg::TX_ASYNC;
                    end else if (tx_go || (wr_ctrl && sync_mode && ctrl_new[9]
                                 && !cfg_q.rx_en)) begin
                        tx_sh_q <= {5'h1F, tx_go ? wb_dat_in[7:0] : 8'hFF}; // (R7)
                        tx_left_q <= 4'h0;
                        syn_rx_q <= !tx_go;
                        rxd_oe <= tx_go; // (R2)
                        tx_st_q <= assc_pkg::TX_SYNC;
                    end
                end
                assc_pkg::TX_ASYNC: begin
                    txd <= tx_sh_q[0];
                    if (tick) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == 4'hF && tx_left_q == 4'h1) begin
                            tx_st_q <= assc_pkg::TX_IDLE;
                        end else if (tx_sub_q == 4'hF) begin
                            tx_sh_q <= {1'b1, tx_sh_q[12:1]}; // (R8)
                            tx_left_q <= tx_left_q - 4'h1;
                        end
                    end
                end
                assc_pkg::TX_SYNC: begin
                    if (tick) begin
                        // data moves on the falling edge, is sampled on the rising
                        if (txd && tx_left_q != 4'h0) begin
                            tx_sh_q[7:0] <= {samp_q, tx_sh_q[7:1]}; // (R8)
                        end
                        if (txd && tx_left_q == 4'h8) begin
                            rxd_oe <= 1'b0;
                            tx_st_q <= assc_pkg::TX_IDLE;
                        end else if (txd) begin
                            txd <= 1'b0; // (R7)
                        end else begin
                            txd <= 1'b1;
                            samp_q <= sync_in;
                            tx_left_q <= tx_left_q + 4'h1;
                        end
                    end
                end
                default: tx_st_q <= assc_pkg::TX_IDLE;
            endcase
        end
    end
    assign rxd_out = tx_sh_q[0];

    // ****************************************************************
    // receive buffer and errors
    // ****************************************************************
    // wake filter drops plain data characters so only addresses wake us
    always_comb begin
        put = 1'b0;
        put_data = 9'h000;
        put_perr = 1'b0;
        put_ferr = 1'b0;
        if (syn_done && syn_rx_q) begin
            put = 1'b1;
            put_data = {1'b0, samp_q, tx_sh_q[7:1]};
        end else if (rxu_done && !(cfg_q.wake_filter && cfg_q.mode == assc_pkg::MODE_AWAKE
                                   && !rxu_res.data[8])) begin // (R6)
            put = 1'b1;
            put_data = rxu_res.data;
            put_perr = rxu_res.par_err;
            put_ferr = rxu_res.frm_err & cfg_q.frm_en; // (R11)
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_full_q <= 1'b0;
            rbuf_q <= '0;
        end else if (ce) begin
            if (rd && wb_adr == assc_pkg::OFS_RXD) rx_full_q <= 1'b0;
            if (put) begin
                rx_full_q <= 1'b1;
                rbuf_q <= put_data;
            end
        end
    end

    assign ev[assc_pkg::IRQ_TBUF] = tbuf_ev;
    assign ev[assc_pkg::IRQ_TXC] = txc_ev;
    assign ev[assc_pkg::IRQ_RX] = put;
    assign ev[assc_pkg::IRQ_ERR] = put & (put_perr | put_ferr | (rx_full_q & cfg_q.ovr_en));
    assign clr = (wr && wb_adr == assc_pkg::OFS_ICLR) ? wb_dat_in[assc_pkg::IRQ_N-1:0]
                                                     : '0;

    // ****************************************************************
    // interrupt status: a set in the clearing cycle wins
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= '0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
        end else if (ce) begin
            stat_q <= (stat_q & ~clr) | ev; // (R4)
            perr_q <= (perr_q & ~clr[assc_pkg::IRQ_ERR]) | (put & put_perr); // (R10)
            ferr_q <= (ferr_q & ~clr[assc_pkg::IRQ_ERR]) | (put & put_ferr); // (R11)
            oerr_q <= (oerr_q & ~clr[assc_pkg::IRQ_ERR])
                      | (put & rx_full_q & cfg_q.ovr_en); // (R12)
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_vec <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            irq_vec <= stat_q & ien_q; // (R4)
            irq <= |(stat_q & ien_q);
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    // a sync receive ends by clearing rx_en, unless software writes ctrl then
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= assc_pkg::CTRL_RST; // (R13)
            baud_q <= assc_pkg::BAUD_RST;
            ien_q <= '0;
        end else if (ce) begin
            if (syn_done && syn_rx_q) cfg_q.rx_en <= 1'b0;
            if (wr_ctrl) cfg_q <= ctrl_new;
            if (wr && wb_adr == assc_pkg::OFS_BAUD) begin
                baud_q <= assc_pkg::BAUD_W'((baud_q & ~wmask) | (wb_dat_in & wmask)); // (R3)
            end
            if (wr && wb_adr == assc_pkg::OFS_IEN) begin
                ien_q <= assc_pkg::IRQ_N'((ien_q & ~wmask) | (wb_dat_in & wmask));
            end
        end
    end

    // ****************************************************************
    // read mux and acknowledge
    // ****************************************************************
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (wb_adr)
            assc_pkg::OFS_CTRL: rdata[assc_pkg::CTRL_W-1:0] = cfg_q;
            assc_pkg::OFS_BAUD: rdata[assc_pkg::BAUD_W-1:0] = baud_q;
            assc_pkg::OFS_RXD: rdata[assc_pkg::DATA_W-1:0] = rbuf_q;
            assc_pkg::OFS_STAT: begin
                rdata[assc_pkg::IRQ_N-1:0] = stat_q;
                rdata[assc_pkg::ST_TXBUSY] = tx_st_q != assc_pkg::TX_IDLE;
                rdata[assc_pkg::ST_RXFULL] = rx_full_q;
                rdata[assc_pkg::ST_PERR] = perr_q;
                rdata[assc_pkg::ST_FERR] = ferr_q;
                rdata[assc_pkg::ST_OERR] = oerr_q;
            end
            assc_pkg::OFS_IEN: rdata[assc_pkg::IRQ_N-1:0] = ien_q;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // unmapped and write-only addresses are acked and read as zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack <= wb_cyc & wb_stb & ~wb_ack;
            if (rd) wb_dat_out <= rdata;
        end
    end
endmodule // assc_top

/* bench/assc_top_assertions.sv */
// concurrent checks on the serial channel top ports, bound into assc_top
`timescale 1ns/100ps
module assc_top_chk (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack,
    input wire logic txd,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    input wire logic irq,
    input wire logic [3:0] irq_vec
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_ack_next: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("request not acked");
    a_ack_single: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    a_rst_idle: assert property ($rose(rst_b) |-> txd && !irq && !rxd_oe && !irq_vec)
        else $error("outputs not idle after reset");
    // async bits last 16 ticks, so no low stretch is shorter than 8 cycles
    a_low_len: assert property ($fell(txd) && !rxd_oe |-> !txd [*8])
        else $error("async low bit too short");
    a_sync_edge: assert property (rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> $fell(txd))
        else $error("sync data moved off the falling edge");
    a_sync_idle: assert property ($fell(rxd_oe) |-> txd)
        else $error("shift clock not idle after byte");
    a_dat_zero: assert property (wb_ack && !wb_we && (wb_adr == 8'h08 || wb_adr[7:5] != 3'h0)
        |-> wb_dat_out == 32'h0)
        else $error("write-only or unmapped read not zero");
    a_irq_src: assert property (irq |-> |irq_vec || $past(|irq_vec))
        else $error("interrupt without a source");
    c_write: cover property (wb_ack && wb_we);
    c_async: cover property ($fell(txd) && !rxd_oe);
    c_irq: cover property ($rose(irq));
endmodule // assc_top_chk

bind assc_top assc_top_chk i_chk (.core_clk, .rst_b, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_dat_out, .wb_ack, .txd, .rxd_out, .rxd_oe, .irq, .irq_vec);

/* bench/assc_peer.sv */
// remote async sender driving the channel's serial input
`timescale 1ns/100ps
module assc_peer #(
    parameter int BIT = 16
) (
    input wire logic core_clk,
    output logic rxd
);
    initial rxd = 1'b1;
    // stop level is a choice so a missing stop bit can be provoked
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            rxd <= f[i];
            repeat (BIT - 1) @(posedge core_clk);
        end
        @(posedge core_clk);
        rxd <= 1'b1;
        repeat (2 * BIT) @(posedge core_clk);
    endtask
endmodule // assc_peer

/* bench/async_sync_serial_channel_tb_top.sv */
// self-checking bench for the serial channel
`timescale 1ns/100ps
module async_sync_serial_channel_tb_top;
    typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} assc_row_t;
    logic core_clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, txd, rxd_in, rxd_out, rxd_oe, irq;
    logic [7:0] wb_adr;
    logic [31:0] wb_dat_in, wb_dat_out, rdat;
    logic [3:0] irq_vec;
    logic [10:0] fr;
    logic [7:0] sb;
    int n_mismatch = 0;
    int checks = 0;
    int cyc_n = 0;
    assc_row_t rows [6] = '{'{8'h00, 1'b1, 32'h1FC, 32'h0}, '{8'h00, 1'b0, 32'h0, 32'h1FC},
        '{8'h04, 1'b1, 32'h1234, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h1234},
        '{8'h40, 1'b0, 32'h0, 32'h0}, '{8'h08, 1'b0, 32'h0, 32'h0}};
    logic [7:0] rst_adr [4] = '{8'h00, 8'h04, 8'h18, 8'h10};
    logic [31:0] rst_exp [4] = '{32'h0, 32'hB, 32'h0, 32'h0};

    assc_top i_dut (.core_clk, .rst_b, .ce(1'b1), .wb_cyc, .wb_stb, .wb_we, .wb_adr,
        .wb_sel(4'hF), .wb_dat_in, .wb_dat_out, .wb_ack, .txd, .rxd_in, .rxd_out, .rxd_oe,
        .irq, .irq_vec);
    assc_peer #(.BIT(16)) i_peer (.core_clk, .rxd(rxd_in));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_in <= d;
        do @(posedge core_clk); while (wb_ack !== 1'b1);
        rdat = wb_dat_out;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    // a hung handshake would otherwise stall the run forever
    initial begin
        forever begin
            @(posedge core_clk);
            cyc_n++;
            if (cyc_n == 20000) begin
                n_mismatch++;
                wrap_up();
            end
        end
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        rst_b = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_dat_in = 32'h0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk(rdat, rows[i].e);
        end
        rst_b <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        chk(32'(txd), 32'h1);
        for (int i = 0; i < 4; i++) begin
            bus(rst_adr[i], 1'b0, 32'h0);
            chk(rdat, rst_exp[i]);
        end
        bus(8'h04, 1'b1, 32'h0);
        bus(8'h00, 1'b1, 32'h8);
        bus(8'h18, 1'b1, 32'h2);
        bus(8'h08, 1'b1, 32'hA5);
        while (txd !== 1'b0) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 11; i++) begin
            fr[i] = txd;
            repeat (16) @(posedge core_clk);
        end
        chk(32'(fr), {21'h0, 1'b1, ^8'hA5, 8'hA5, 1'b0});
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h1);
        chk(32'(irq_vec), 32'h2);
        bus(8'h10, 1'b0, 32'h0);
        chk(32'(rdat[3:0]), 32'h3);
        bus(8'h14, 1'b1, 32'h2);
        repeat (3) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        bus(8'h00, 1'b1, 32'h260);
        i_peer.send(8'h3C, 1'b1);
        bus(8'h10, 1'b0, 32'h0);
        chk(32'(rdat[12:9]), 32'h1);
        bus(8'h0C, 1'b0, 32'h0);
        chk(rdat, 32'h3C);
        i_peer.send(8'h81, 1'b1);
        i_peer.send(8'h42, 1'b1);
        bus(8'h10, 1'b0, 32'h0);
        chk(32'(rdat[12:9]), 32'h9);
        bus(8'h0C, 1'b0, 32'h0);
        chk(rdat, 32'h42);
        bus(8'h14, 1'b1, 32'hF);
        i_peer.send(8'h11, 1'b0);
        bus(8'h10, 1'b0, 32'h0);
        chk(32'(rdat[12:9]), 32'h5);
        bus(8'h0C, 1'b0, 32'h0);
        bus(8'h00, 1'b1, 32'h268);
        i_peer.send(8'h3C, 1'b1);
        bus(8'h10, 1'b0, 32'h0);
        chk(32'(rdat[12:9]), 32'h7);
        bus(8'h0C, 1'b0, 32'h0);
        for (int m = 0; m < 3; m++) begin
            bus(8'h00, 1'b1, 32'h280 | 32'(m));
            bus(8'h08, 1'b1, 32'h1A5);
            do bus(8'h10, 1'b0, 32'h0); while (rdat[9] !== 1'b1);
            bus(8'h0C, 1'b0, 32'h0);
            chk(rdat, (m == 0) ? 32'hA5 : 32'h1A5);
        end
        bus(8'h00, 1'b1, 32'h382);
        bus(8'h08, 1'b1, 32'h0A5);
        do bus(8'h10, 1'b0, 32'h0); while (rdat[8] !== 1'b0);
        chk(32'(rdat[9]), 32'h0);
        bus(8'h04, 1'b1, 32'h7);
        bus(8'h00, 1'b1, 32'h3);
        bus(8'h08, 1'b1, 32'h96);
        for (int i = 0; i < 8; i++) begin
            while (txd !== 1'b0) @(posedge core_clk);
            while (txd !== 1'b1) @(posedge core_clk);
            sb[i] = rxd_out;
        end
        chk(32'(sb), 32'h96);
        chk(32'(rxd_oe), 32'h1);
        do bus(8'h10, 1'b0, 32'h0); while (rdat[8] !== 1'b0);
        bus(8'h00, 1'b1, 32'h203);
        do bus(8'h10, 1'b0, 32'h0); while (rdat[9] !== 1'b1);
        bus(8'h0C, 1'b0, 32'h0);
        chk(rdat, 32'hFF);
        wrap_up();
    end
endmodule // async_sync_serial_channel_tb_top
